// file: hdl/sas_regs.vh
// constants for the successive-approximation conversion sequencer
`ifndef SAS_REGS_VH
`define SAS_REGS_VH
// conversion lengths, in half converter clock cycles
`define SAS_LEN_NORMAL 6'h1A
`define SAS_LEN_FIRST 6'h32
`define SAS_LEN_DIFF 6'h1C
// sample-and-hold points, in half converter clock cycles
`define SAS_SMP_NORMAL 6'h03
`define SAS_SMP_FIRST 6'h1B
`define SAS_SMP_AUTO 6'h04
`define SAS_SMP_DIFF 6'h05
// trigger select code meaning "conversion complete flag"
`define SAS_TS_FREE 3'h0
// channel select codes above the single-ended range
`define SAS_CH_DIFF_LO 5'h08
`define SAS_CH_BANDGAP 5'h1E
`define SAS_CH_GROUND 5'h1F
// result register reset value
`define SAS_RESULT_RST 8'h00
`endif

// file: hdl/sas_sequencer.v
// conversion sequencer: prescaler, starts, timing, result lock and flag
`default_nettype none
`include "sas_regs.vh"
// Notes on behaviour
// (RQ1) selections apply only while enabled; else idle
// (RQ2) result right-justified, or left when asked
// (RQ3) low byte read blocks result updates
// (RQ4) blocked completion discards its result
// (RQ5) high byte read re-enables updates
// (RQ6) complete flag still sets during lock
// (RQ7) start bit begins, holds, clears at end
// (RQ8) channel change waits for conversion end
// (RQ9) auto trigger edge resets prescaler, starts
// (RQ10) edges during conversion ignored, no relevel
// (RQ11) trigger flag needs clearing between events
// (RQ12) complete-flag source restarts back to back
// (RQ13) start bit reads one during any conversion
// (RQ14) prescaler counts when enabled, else reset
// (RQ15) user start waits for converter clock edge
// (RQ16) 13 cycles normal, 25 first
// (RQ17) sample at 1.5, or 13.5 first
// (RQ18) completion writes result, flags, clears start
// (RQ19) auto trigger samples 2 cycles after edge
// (RQ20) differential auto trigger needs re-enable
// (RQ21) free running keeps start bit set
// (RQ22) single-ended bypasses gain; differential uses it
// (RQ23) differential 13 or 14 by phase
// (RQ24) selection buffer locked during conversion
// (RQ25) irq while flag and enable; clear paths
// (RQ26) prescaler divides by 2 through 128
module sas_sequencer (
  // clock and reset
  input wire core_clk_in,
  input wire reset_n_in,
  // control bits
  input wire conv_enable_in,
  input wire start_conversion_wr_in,
  input wire auto_trigger_enable_in,
  input wire [2:0] trigger_select_in,
  input wire [7:0] trigger_sources_in,
  input wire [2:0] prescale_select_in,
  input wire left_adjust_result_in,
  input wire conversion_irq_enable_in,
  input wire done_flag_clear_in,
  input wire irq_ack_in,
  // selections written by software
  input wire [4:0] channel_select_in,
  input wire [1:0] reference_select_in,
  // result register reads
  input wire result_low_read_in,
  input wire result_high_read_in,
  // analog core answer
  input wire [9:0] sar_result_in,
  // status and results
  output reg start_conversion_out,
  output reg conversion_done_flag_out,
  output reg conv_irq_out,
  output reg [7:0] result_high_byte_out,
  output reg [7:0] result_low_byte_out,
  // analog core control
  output reg analog_power_out,
  output reg sample_hold_out,
  output reg [4:0] channel_select_out,
  output reg [1:0] reference_select_out,
  output reg gain_bypass_out,
  output reg half_rate_phase_clock_out
);
  // one-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  // differential when between single-ended pins and bandgap/ground
  function is_diff;
    input [4:0] ch;
    begin
      is_diff = (ch >= `SAS_CH_DIFF_LO) && (ch < `SAS_CH_BANDGAP);
    end
  endfunction

  reg [2:0] state; // sequencer state
  reg [6:0] pre_cnt; // prescaler count
  reg [5:0] hcnt; // half cycles into conversion
  reg [5:0] cur_len; // length of running conversion
  reg [5:0] cur_smp; // sample point of running conversion
  reg first_conv; // next conversion is the long one
  reg locked; // result registers blocked
  reg [2:0] trig_d; // trigger synchroniser delay
  reg [6:0] div_m1; // prescale divide minus one
  reg [6:0] half_m1; // half divide minus one
  reg rise_tick; // converter clock rising edge
  reg half_tick; // either converter clock edge
  reg trig_sel; // selected trigger source level
  reg trig_edge; // qualified trigger edge
  reg free_run; // complete flag is the source
  reg done; // conversion finishes this cycle
  reg restart; // back to back restart at done
  reg [5:0] next_hcnt;

  // (RQ26) divide by 2..128
  always @* begin
    if (prescale_select_in == 3'h0) begin
      div_m1 = 7'h01;
    end else begin
      div_m1 = (7'h01 << prescale_select_in) - 7'h01;
    end
    half_m1 = div_m1 >> 1;
    rise_tick = conv_enable_in && (pre_cnt == div_m1);
    half_tick = rise_tick || (conv_enable_in && (pre_cnt == half_m1));
  end

  // trigger selection and qualification
  always @* begin
    trig_sel = trigger_sources_in[trigger_select_in];
    free_run = auto_trigger_enable_in && (trigger_select_in == `SAS_TS_FREE);
    // (RQ10) only edges seen outside a conversion count
    // (RQ11) level must fall before next edge
    trig_edge = conv_enable_in && auto_trigger_enable_in && !free_run &&
                trig_d[1] && !trig_d[2] && (state != ST_CONV);
    next_hcnt = hcnt + 6'h01;
    done = (state == ST_CONV) && half_tick && (next_hcnt == cur_len);
    // (RQ12) restart whatever the flag holds
    restart = done && free_run;
  end

  // trigger delay line; inputs are synchronous so no metastability risk
  // (RQ19) three cpu cycles of synchronisation
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trig_d <= 3'h0;
    end else begin
      trig_d <= {trig_d[1:0], trig_sel};
    end
  end

  // prescaler
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_cnt <= 7'h00;
    end else if (!conv_enable_in) begin
      // (RQ14) held in reset while off
      pre_cnt <= 7'h00;
    end else if (trig_edge) begin
      // (RQ9) trigger resets prescaler
      pre_cnt <= 7'h00;
    end else if (pre_cnt >= div_m1) begin
      // wrap at once if a smaller divide is picked mid-count
      pre_cnt <= 7'h00;
    end else begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // half-rate phase clock follows converter clock rises
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      half_rate_phase_clock_out <= 1'b0;
    end else if (!conv_enable_in) begin
      half_rate_phase_clock_out <= 1'b0;
    end else if (rise_tick) begin
      half_rate_phase_clock_out <= !half_rate_phase_clock_out;
    end
  end

  // conversion sequencer
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      hcnt <= 6'h00;
      cur_len <= `SAS_LEN_NORMAL;
      cur_smp <= `SAS_SMP_NORMAL;
      first_conv <= 1'b1;
      start_conversion_out <= 1'b0;
      sample_hold_out <= 1'b0;
    end else if (!conv_enable_in) begin
      // (RQ1) powered down, idle; next start is the long one
      // (RQ20) disabling rearms the extended conversion
      state <= ST_IDLE;
      hcnt <= 6'h00;
      first_conv <= 1'b1;
      start_conversion_out <= 1'b0;
      sample_hold_out <= 1'b0;
    end else begin
      sample_hold_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (trig_edge) begin
            // (RQ19) start aligned to reset prescaler
            state <= ST_CONV;
            hcnt <= 6'h00;
            start_conversion_out <= 1'b1;
            first_conv <= 1'b0;
            cur_len <= first_conv ? `SAS_LEN_FIRST : `SAS_LEN_NORMAL;
            cur_smp <= first_conv ? `SAS_SMP_FIRST : `SAS_SMP_AUTO;
          end else if (start_conversion_wr_in) begin
            // (RQ13) start write also works under auto trigger
            state <= ST_WAIT;
            start_conversion_out <= 1'b1;
          end
        end
        ST_WAIT: begin
          // (RQ15) begin on next converter clock rise
          if (rise_tick) begin
            state <= ST_CONV;
            hcnt <= 6'h00;
            first_conv <= 1'b0;
            if (first_conv) begin
              // (RQ16) first conversion 25 cycles
              cur_len <= `SAS_LEN_FIRST;
              cur_smp <= `SAS_SMP_FIRST;
            end else if (is_diff(channel_select_out) && !half_rate_phase_clock_out) begin
              // (RQ23) phase high after this rise: 14 cycles
              cur_len <= `SAS_LEN_DIFF;
              cur_smp <= `SAS_SMP_DIFF;
            end else begin
              cur_len <= `SAS_LEN_NORMAL;
              cur_smp <= `SAS_SMP_NORMAL;
            end
          end
        end
        ST_CONV: begin
          if (half_tick) begin
            hcnt <= next_hcnt;
          end
          // (RQ17) sample at its half-cycle point
          if (half_tick && (next_hcnt == cur_smp)) begin
            sample_hold_out <= 1'b1;
          end
          if (restart) begin
            // (RQ21) start bit stays set
            hcnt <= 6'h00;
            cur_len <= is_diff(channel_select_out) ? `SAS_LEN_DIFF : `SAS_LEN_NORMAL;
            cur_smp <= is_diff(channel_select_out) ? `SAS_SMP_DIFF : `SAS_SMP_NORMAL;
          end else if (done) begin
            // (RQ7) hardware clears the start bit
            // (RQ18) same cycle as result and flag
            state <= ST_IDLE;
            start_conversion_out <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          start_conversion_out <= 1'b0;
        end
      endcase
    end
  end

  // selection buffer toward the analog core
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      channel_select_out <= 5'h00;
      reference_select_out <= 2'h0;
      gain_bypass_out <= 1'b1;
      analog_power_out <= 1'b0;
    end else begin
      analog_power_out <= conv_enable_in;
      // (RQ24) follow outside a conversion or in its last three half cycles
      // (RQ8) locked so the running channel finishes
      if (conv_enable_in && ((state != ST_CONV) || (next_hcnt >= cur_len - 6'h02))) begin
        channel_select_out <= channel_select_in;
        reference_select_out <= reference_select_in;
        // (RQ22) gain stage only for differential pairs
        gain_bypass_out <= !is_diff(channel_select_in);
      end
    end
  end

  // result registers and read lock
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      locked <= 1'b0;
      result_high_byte_out <= `SAS_RESULT_RST;
      result_low_byte_out <= `SAS_RESULT_RST;
    end else begin
      // (RQ5) high read releases; it wins over a low read
      if (result_high_read_in) begin
        locked <= 1'b0;
      end else if (result_low_read_in) begin
        // (RQ3) low read locks both bytes
        locked <= 1'b1;
      end
      // (RQ4) discard while locked
      if (done && !locked) begin
        // (RQ2) alignment of the 10-bit result
        if (left_adjust_result_in) begin
          result_high_byte_out <= sar_result_in[9:2];
          result_low_byte_out <= {sar_result_in[1:0], 6'h00};
        end else begin
          result_high_byte_out <= {6'h00, sar_result_in[9:8]};
          result_low_byte_out <= sar_result_in[7:0];
        end
      end
    end
  end

  // complete flag and interrupt; a completion beats a clear
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conversion_done_flag_out <= 1'b0;
      conv_irq_out <= 1'b0;
    end else if (done) begin
      // (RQ6) flag sets even when result is dropped
      conversion_done_flag_out <= 1'b1;
      conv_irq_out <= conversion_irq_enable_in;
    end else if (done_flag_clear_in || irq_ack_in) begin
      // (RQ25) cleared by write-one or service
      conversion_done_flag_out <= 1'b0;
      conv_irq_out <= 1'b0;
    end else begin
      conv_irq_out <= conversion_done_flag_out && conversion_irq_enable_in;
    end
  end
endmodule
`default_nettype wire

// file: testbench/sas_analog_model.sv
// behavioural analog core that answers the conversion sequencer
`default_nettype none
module sas_analog_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control from the sequencer
  input wire logic power_in,
  input wire logic sample_in,
  input wire logic [4:0] ch_in,
  input wire logic [1:0] ref_in,
  // conversion value
  output logic [9:0] value_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held; // value caught at the sample point
  // capture at sample
  // value carries the buffered selection, so a stale channel shows up
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held <= 10'h000;
    end else if (sample_in) begin
      held <= {ch_in, ref_in, 3'h5};
    end
  end
  // unpowered core
  // no stable value while off, so a late sample is caught out
  assign value_out = power_in ? held : ~held;
endmodule
`default_nettype wire

// file: testbench/sas_sequencer_props.sv
// assertion checker for the conversion sequencer ports
`default_nettype none
module sas_sequencer_props (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // watched inputs
  input wire logic conv_enable_in,
  input wire logic start_conversion_wr_in,
  input wire logic conversion_irq_enable_in,
  input wire logic result_low_read_in,
  input wire logic result_high_read_in,
  // watched outputs
  input wire logic start_conversion_out,
  input wire logic conversion_done_flag_out,
  input wire logic conv_irq_out,
  input wire logic [7:0] result_high_byte_out,
  input wire logic [7:0] result_low_byte_out,
  input wire logic analog_power_out,
  input wire logic sample_hold_out,
  input wire logic [4:0] channel_select_out,
  input wire logic gain_bypass_out,
  input wire logic half_rate_phase_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic lock_q; // mirrors the result read lock
  // low read locks, high read frees; high wins when both come together
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_q <= 1'b0;
    end else if (result_high_read_in) begin
      lock_q <= 1'b0;
    end else if (result_low_read_in) begin
      lock_q <= 1'b1;
    end
  end
  // lock held through a cycle with no high read
  sequence s_locked;
    lock_q && !result_high_read_in;
  endsequence
  // flag and enable both held for two samples
  sequence s_irq_cause;
    (conversion_done_flag_out && conversion_irq_enable_in) [*2];
  endsequence
  AST_OFF_IDLE: assert property (!conv_enable_in [*2] |->
    !start_conversion_out && !sample_hold_out) else $error("busy while disabled");
  AST_POWER: assert property (1'b1 |=>
    analog_power_out == $past(conv_enable_in)) else $error("power not following enable");
  AST_HALF_CLK: assert property (!conv_enable_in |=>
    !half_rate_phase_clock_out) else $error("phase clock runs while disabled");
  AST_LOCK: assert property (s_locked |=> $stable(result_high_byte_out) &&
    $stable(result_low_byte_out)) else $error("result changed while locked");
  AST_START: assert property (start_conversion_wr_in && conv_enable_in &&
    !start_conversion_out |=> start_conversion_out) else $error("start bit not set");
  AST_SMP_PULSE: assert property (sample_hold_out |=>
    !sample_hold_out) else $error("sample pulse too long");
  AST_SMP_BUSY: assert property (sample_hold_out |->
    start_conversion_out) else $error("sample without start bit");
  AST_DONE_FLAG: assert property ($fell(start_conversion_out) && conv_enable_in &&
    $past(conv_enable_in) |-> conversion_done_flag_out) else $error("no done flag");
  AST_IRQ: assert property (s_irq_cause |-> conv_irq_out)
    else $error("interrupt missing");
  AST_NO_IRQ: assert property (!conversion_done_flag_out [*2] |-> !conv_irq_out)
    else $error("interrupt without flag");
  AST_GAIN: assert property (gain_bypass_out == (channel_select_out < 5'h08 ||
    channel_select_out > 5'h1D)) else $error("gain bypass wrong");
endmodule
bind sas_sequencer sas_sequencer_props i_props (.core_clk_in, .reset_n_in,
  .conv_enable_in, .start_conversion_wr_in, .conversion_irq_enable_in, .result_low_read_in,
  .result_high_read_in, .start_conversion_out, .conversion_done_flag_out, .conv_irq_out,
  .result_high_byte_out, .result_low_byte_out, .analog_power_out, .sample_hold_out,
  .channel_select_out, .gain_bypass_out, .half_rate_phase_clock_out);
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the conversion sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, en = 0, wr = 0, ate = 0, la = 0, ie = 0, clr = 0, ack = 0;
  logic rd_lo = 0, rd_hi = 0; // result byte reads
  logic [2:0] ts = 3'h0, ps = 3'h0;
  logic [7:0] src = 8'h00; // trigger flags of other blocks
  logic [4:0] ch = 5'h03, ch_o;
  logic [1:0] rs = 2'h1, rs_o;
  logic [9:0] sar, v; // core value and expected result
  logic st, flg, irq, pwr, smp, gb, hclk;
  logic [7:0] hi, lo;
  logic [15:0] snap; // results held across a lock
  int bad_count = 0, checks_done = 0, n, s, k, d;
  always #20 clk = ~clk;
  sas_sequencer i_dut (.core_clk_in(clk), .reset_n_in(rst_n), .conv_enable_in(en),
    .start_conversion_wr_in(wr), .auto_trigger_enable_in(ate), .trigger_select_in(ts),
    .trigger_sources_in(src), .prescale_select_in(ps), .left_adjust_result_in(la),
    .conversion_irq_enable_in(ie), .done_flag_clear_in(clr), .irq_ack_in(ack),
    .channel_select_in(ch), .reference_select_in(rs), .result_low_read_in(rd_lo),
    .result_high_read_in(rd_hi), .sar_result_in(sar), .start_conversion_out(st),
    .conversion_done_flag_out(flg), .conv_irq_out(irq), .result_high_byte_out(hi),
    .result_low_byte_out(lo), .analog_power_out(pwr), .sample_hold_out(smp),
    .channel_select_out(ch_o), .reference_select_out(rs_o), .gain_bypass_out(gb),
    .half_rate_phase_clock_out(hclk));
  sas_analog_model i_core (.clk_in(clk), .rst_n_in(rst_n), .power_in(pwr), .sample_in(smp),
    .ch_in(ch_o), .ref_in(rs_o), .value_out(sar));
  // compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // inputs move on falling edges only
  task cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // optional start write, then bounded wait for the start bit to drop;
  // the channel input is swapped at the sample point to probe the buffer
  task run(input logic [4:0] nch, input logic go);
    n = 0;
    s = 0;
    v = {ch, rs, 3'h5};
    wr = go;
    cyc(1);
    wr = 0;
    while (st !== 1'b0 && n < 5000) begin
      if (smp === 1'b1) begin
        s = n;
        ch = nch;
      end
      cyc(1);
      n++;
    end
    if (n >= 5000) begin
      bad_count++;
      stop_test;
    end
  endtask
  // result alignment for the current expectation
  task res(input logic l);
    chk(16'(hi), l ? 16'(v[9:2]) : 16'(v[9:8]), "high byte");
    chk(16'(lo), l ? 16'({v[1:0], 6'h00}) : 16'(v[7:0]), "low byte");
  endtask
  initial begin
    cyc(8);
    rst_n = 1;
    run(ch, 1'b1);
    chk(16'(pwr), 0, "power off");
    chk(16'(n), 0, "start while off");
    en = 1;
    cyc(2);
    run(ch, 1'b1);
    chk(16'(n >= 51 && n <= 54), 1, "first length");
    res(1'b0);
    chk(16'(flg), 1, "done flag");
    $display("end first");
    for (k = 0; k < 8; k++) begin
      ps = k[2:0];
      la = k[0];
      ie = k[0];
      ch = k[4:0];
      clr = 1;
      cyc(1);
      clr = 0;
      run(5'h10 + k[4:0], 1'b1);
      chk(16'(n - s), 16'(23 * (k == 0 ? 1 : 1 << (k - 1))), "sample to end");
      // wait for the next converter clock rise, then 13 converter clocks
      d = k == 0 ? 2 : 1 << k;
      chk(16'(n > 13 * d && n <= 14 * d), 1, "start to end");
      res(la);
      chk(16'(ch_o), 16'(5'h10 + k[4:0]), "buffer resumes");
      cyc(2);
      chk(16'(irq), 16'(ie), "irq");
      ack = 1;
      cyc(1);
      ack = 0;
      cyc(1);
      chk(16'(flg), 0, "flag ack");
    end
    $display("end prescale");
    {ps, la, ie} = 5'h00;
    snap = {hi, lo};
    rd_lo = 1;
    cyc(1);
    rd_lo = 0;
    run(ch, 1'b1);
    chk({hi, lo}, snap, "locked result");
    chk(16'(flg), 1, "flag in lock");
    rd_hi = 1;
    cyc(1);
    rd_hi = 0;
    run(ch, 1'b1);
    res(1'b0);
    $display("end lock");
    ate = 1;
    wr = 1;
    cyc(1);
    wr = 0;
    {n, s} = 0;
    repeat (200) begin
      cyc(1);
      s += (smp === 1'b1);
      n += (st !== 1'b1);
    end
    chk(16'(n), 0, "start dropped");
    chk(16'(s >= 7), 1, "back to back");
    ate = 0;
    run(ch, 1'b0);
    $display("end free run");
    // divide by 8 so that the prescaler reset shows in the sample delay
    {ts, ate, ps} = 7'h1B;
    cyc(4);
    src[1] = 1;
    {n, s} = 0;
    for (k = 0; k < 150; k++) begin
      cyc(1);
      if (k == 10) src[1] = 0;
      if (k == 12) src[1] = 1;
      if (smp === 1'b1) n = k;
      s += (smp === 1'b1);
    end
    chk(16'(s), 1, "one trigger");
    // three sync cycles, then two converter clocks of eight cycles each
    chk(16'(n), 18, "trigger to sample");
    {src, ate} = 9'h000;
    $display("end trigger");
    en = 0;
    cyc(2);
    chk(16'(hclk), 0, "phase clock off");
    stop_test;
  end
endmodule
`default_nettype wire
